// ===== hdl/pdsi_cfg.svh
// Constants for the parallel sample interface between a sample source and a converter model.
// Assumes one clock domain, core_clk at 125 MHz, and an asynchronous active-high reset.
// Summary of operation
// - Sample word is 14 bits, MSB on top.
// - Code is unsigned straight binary, 0 to 16383.
// - All ones: primary full, complementary zero.
// - Primary is code; complementary is 16383 minus code.
// - Differential is twice code minus 16383.
// - Capture word on each rising conversion clock.
// - Clock up to 210 MSPS, one word per clock.
// - Source changes data on falling clock edge.
// - Clock mode strap selects receiver type.
// - Single-ended mode drives positive clock only.
// - Decode five thermometer, four thermometer, rest binary.
// - Sleep kills output within 50 ns, recovers 5 us; the model zeroes the outputs 10 core cycles (80 ns) after the sleep pin rises.
`ifndef PDSI_CFG_SVH
`define PDSI_CFG_SVH
`define PDSI_DATA_W        14
`define PDSI_CODE_MAX      14'h3fff
`define PDSI_CODE_ZERO     14'h0000
`define PDSI_UPPER_W       5
`define PDSI_MID_W         4
`define PDSI_LSB_W         5
`define PDSI_UPPER_SRC     31
`define PDSI_MID_SRC       15
`define PDSI_CLK_MHZ       125
`define PDSI_MAX_MSPS      210
`define PDSI_SLEEP_OFF_NS  50
`define PDSI_WAKE_US       5
`define PDSI_SLEEP_CYC     ((`PDSI_SLEEP_OFF_NS * `PDSI_CLK_MHZ) / 1000)
`define PDSI_WAKE_CYC      (`PDSI_WAKE_US * `PDSI_CLK_MHZ)
`define PDSI_DIV_DEFAULT   2
`define PDSI_STRAP_SETTLE  2'h3
`endif

// ===== hdl/pdsi_pkg.sv
// Types shared by the converter end of the parallel sample interface and its bench.
// Assumes the constants header is compiled alongside.
`include "pdsi_cfg.svh"
package pdsi_pkg;
    typedef logic [`PDSI_DATA_W-1:0] pdsi_code_t;
    typedef logic signed [`PDSI_DATA_W+1:0] pdsi_diff_t;
    typedef enum logic [1:0] {
        PDSI_CLK_SINGLE = 2'h0,
        PDSI_CLK_DIFF   = 2'h1,
        PDSI_CLK_PECL   = 2'h2
    } pdsi_clk_mode_e;
    typedef enum logic [1:0] {
        PDSI_PWR_ON    = 2'h0,
        PDSI_PWR_DOWN  = 2'h1,
        PDSI_PWR_OFF   = 2'h2,
        PDSI_PWR_WAKE  = 2'h3
    } pdsi_pwr_e;
endpackage

// ===== hdl/pdsi_if.sv
// Interface joining the sample source and the converter end.
// The conversion clock is a pin signal generated by the source from core_clk.
`timescale 1ns/1ps
`include "pdsi_cfg.svh"
interface pdsi_if;
    logic                   conv_clk_p;
    logic                   conv_clk_n;
    logic                   conv_clk_n_oe;
    logic [`PDSI_DATA_W-1:0] sample_word;
    logic                   sleep;
    modport source (output conv_clk_p, output conv_clk_n, output conv_clk_n_oe, output sample_word, output sleep);
    modport converter (input conv_clk_p, input conv_clk_n, input conv_clk_n_oe, input sample_word, input sleep);
endinterface

// ===== hdl/pdsi_source.sv
// Sample source end: divides core_clk into a conversion clock and presents one word per period.
// Assumes the user offers words with a valid/ready handshake on core_clk.
`timescale 1ns/1ps
`include "pdsi_cfg.svh"
module pdsi_source #(
    parameter int DIV_HALF = `PDSI_DIV_DEFAULT
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    // User side
    input  wire logic [`PDSI_DATA_W-1:0] user_word,
    input  wire logic                    user_valid,
    output      logic                    user_ready,
    input  wire logic                    user_sleep,
    input  wire logic                    single_ended,
    // Link
    pdsi_if.source                       link
);
    // Half period of DIV_HALF core cycles keeps the clock at 50% duty and below 210 MSPS.
    // The divider counter is eight bits wide, which bounds the half period.
    if (DIV_HALF < 1 || DIV_HALF > 256 || `PDSI_CLK_MHZ / (2 * DIV_HALF) > `PDSI_MAX_MSPS) begin : g_bad_div
        $error("pdsi_source: DIV_HALF out of range");
    end
    logic [7:0]              cnt;
    logic [7:0]              next_cnt;
    logic                    clk_q;
    logic                    next_clk_q;
    logic [`PDSI_DATA_W-1:0] word_q;
    logic [`PDSI_DATA_W-1:0] next_word_q;
    logic                    sleep_q;
    logic                    next_sleep_q;
    logic                    fall;

    always_comb begin
        next_cnt    = cnt + 8'h01;
        next_clk_q  = clk_q;
        next_word_q = word_q;
        fall        = 1'b0;
        if (cnt == 8'(DIV_HALF - 1)) begin
            next_cnt   = 8'h00;
            next_clk_q = ~clk_q;
            fall       = clk_q;
        end
        next_sleep_q = user_sleep;
        if (fall) begin
            next_word_q = user_valid ? user_word : word_q;
        end
    end
    assign user_ready = fall;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt     <= 8'h00;
            clk_q   <= 1'b0;
            word_q  <= `PDSI_CODE_ZERO;
            sleep_q <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            clk_q   <= next_clk_q;
            word_q  <= next_word_q;
            sleep_q <= next_sleep_q;
        end
    end

    assign link.conv_clk_p    = clk_q;
    // An undriven negative pin is shown at the wrong level, so a converter that still reads it loses its clock.
    assign link.conv_clk_n    = single_ended ? clk_q : ~clk_q;
    assign link.conv_clk_n_oe = ~single_ended;
    assign link.sample_word   = word_q;
    assign link.sleep         = sleep_q;
endmodule // pdsi_source

// ===== hdl/pdsi_converter.sv
// Converter end: latches samples on conversion clock rising edges and models output currents as codes.
// Assumes the conversion clock pin is slower than core_clk/2; all pins are synchronised first.
`timescale 1ns/1ps
`include "pdsi_cfg.svh"
module pdsi_converter #(
    parameter int SLEEP_CYC = `PDSI_SLEEP_CYC,
    parameter int WAKE_CYC  = `PDSI_WAKE_CYC
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    // Strap: 0 tied to clock ground, 1 tied to clock supply, 2 floating
    input  wire logic [1:0]              clock_mode_strap,
    // Link
    pdsi_if.converter                    link,
    // Model outputs
    output      logic [`PDSI_DATA_W-1:0] primary_current_output,
    output      logic [`PDSI_DATA_W-1:0] complementary_current_output,
    output      pdsi_pkg::pdsi_diff_t    differential_output,
    output      logic [`PDSI_UPPER_SRC-1:0] upper_sources_on,
    output      logic [`PDSI_MID_SRC-1:0]   middle_sources_on,
    output      logic [`PDSI_LSB_W-1:0]     binary_bits,
    output      pdsi_pkg::pdsi_clk_mode_e   clock_mode,
    output      logic                    powered_down
);
    // The power timer is sixteen bits wide, which bounds both counts.
    if (SLEEP_CYC < 1 || SLEEP_CYC > 65535 || WAKE_CYC < 1 || WAKE_CYC > 65535) begin : g_bad_timing
        $error("pdsi_converter: bad timing count");
    end

    // Thermometer code with the low v bits set; shared by the upper and middle source arrays.
    function automatic logic [30:0] thermo(input logic [4:0] v);
        logic [30:0] t;
        t = '0;
        for (int i = 0; i < 31; i++) begin
            t[i] = (5'(i) < v);
        end
        return t;
    endfunction

    logic [2:0]              clk_sync;
    logic [`PDSI_DATA_W-1:0] d_s1;
    logic [`PDSI_DATA_W-1:0] d_s2;
    logic [1:0]              sleep_sync;
    logic                    clk_rise;
    logic                    clk_in;
    logic [`PDSI_DATA_W-1:0] code;
    logic [`PDSI_DATA_W-1:0] next_code;
    pdsi_pkg::pdsi_pwr_e     pwr;
    pdsi_pkg::pdsi_pwr_e     next_pwr;
    // Sixteen timer bits hold the default wake count with ample margin.
    logic [15:0]             tmr;
    logic [15:0]             next_tmr;
    pdsi_pkg::pdsi_clk_mode_e next_mode;
    logic [1:0]              strap_s1;
    logic [1:0]              strap_s2;
    logic [1:0]              mode_wait;
    logic [1:0]              next_mode_wait;

    logic [`PDSI_DATA_W-1:0]    next_primary;
    logic [`PDSI_DATA_W-1:0]    next_complementary;
    pdsi_pkg::pdsi_diff_t       next_differential;
    logic [`PDSI_UPPER_SRC-1:0] next_upper;
    logic [`PDSI_UPPER_SRC-1:0] mid_thermo;
    logic [`PDSI_MID_SRC-1:0]   next_middle;
    logic [`PDSI_LSB_W-1:0]     next_binary;

    // single-ended mode uses only the positive clock pin.
    // In that mode the negative pin is undriven, so it must not gate the clock.
    always_comb begin
        unique case (clock_mode)
            pdsi_pkg::PDSI_CLK_SINGLE: clk_in = link.conv_clk_p;
            default:                   clk_in = link.conv_clk_p & ~link.conv_clk_n;
        endcase
    end

    // The strap is a board pin: it is synchronised, then taken once after it has settled.
    // Until then the single-ended default is used, which the differential pins also satisfy.
    always_comb begin
        next_mode_wait = mode_wait;
        next_mode      = clock_mode;
        if (mode_wait != `PDSI_STRAP_SETTLE) begin
            next_mode_wait = mode_wait + 2'h1;
        end
        if (mode_wait == `PDSI_STRAP_SETTLE - 2'h1) begin
            unique case (strap_s2)
                2'h0:    next_mode = pdsi_pkg::PDSI_CLK_SINGLE;
                2'h1:    next_mode = pdsi_pkg::PDSI_CLK_DIFF;
                default: next_mode = pdsi_pkg::PDSI_CLK_PECL;
            endcase
        end
    end

    // Data is sampled from the second flop; source changes it half a clock before the edge.
    // The third flop only remembers the previous level for the rising-edge detector.
    assign clk_rise = clk_sync[1] & ~clk_sync[2];
    always_comb begin
        next_code = code;
        if (clk_rise) begin
            next_code = d_s2;
        end
    end

    // The sleep timer models off within SLEEP_CYC and about WAKE_CYC to recover.
    // Sleep raised again during wake-up returns to off at once; the sources never settled.
    always_comb begin
        next_pwr = pwr;
        next_tmr = (tmr == 16'h0000) ? tmr : tmr - 16'h0001;
        unique case (pwr)
            pdsi_pkg::PDSI_PWR_ON: begin
                if (sleep_sync[1]) begin
                    next_pwr = pdsi_pkg::PDSI_PWR_DOWN;
                    next_tmr = 16'(SLEEP_CYC - 1);
                end
            end
            pdsi_pkg::PDSI_PWR_DOWN: begin
                if (tmr == 16'h0000) begin
                    next_pwr = pdsi_pkg::PDSI_PWR_OFF;
                end
            end
            pdsi_pkg::PDSI_PWR_OFF: begin
                if (!sleep_sync[1]) begin
                    next_pwr = pdsi_pkg::PDSI_PWR_WAKE;
                    next_tmr = 16'(WAKE_CYC - 1);
                end
            end
            pdsi_pkg::PDSI_PWR_WAKE: begin
                if (sleep_sync[1]) begin
                    next_pwr = pdsi_pkg::PDSI_PWR_OFF;
                end else if (tmr == 16'h0000) begin
                    next_pwr = pdsi_pkg::PDSI_PWR_ON;
                end
            end
        endcase
    end

    // Every pin passes two flops before use; the clock pins are first combined into clk_in.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            clk_sync   <= 3'h0;
            d_s1       <= `PDSI_CODE_ZERO;
            d_s2       <= `PDSI_CODE_ZERO;
            sleep_sync <= 2'h0;
            code       <= `PDSI_CODE_ZERO;
            pwr        <= pdsi_pkg::PDSI_PWR_ON;
            tmr        <= 16'h0000;
            clock_mode <= pdsi_pkg::PDSI_CLK_SINGLE;
            strap_s1   <= 2'h0;
            strap_s2   <= 2'h0;
            mode_wait  <= 2'h0;
        end else begin
            clk_sync   <= {clk_sync[1:0], clk_in};
            d_s1       <= link.sample_word;
            d_s2       <= d_s1;
            sleep_sync <= {sleep_sync[0], link.sleep};
            code       <= next_code;
            pwr        <= next_pwr;
            tmr        <= next_tmr;
            strap_s1   <= clock_mode_strap;
            strap_s2   <= strap_s1;
            mode_wait  <= next_mode_wait;
            clock_mode <= next_mode;
        end
    end

    // Outputs stay off during wake-up as well, since the sources are still settling then.
    assign powered_down = (pwr == pdsi_pkg::PDSI_PWR_OFF) || (pwr == pdsi_pkg::PDSI_PWR_WAKE);

    // Currents are modelled as codes of 1/16384 full scale; both zero while powered down.
    // Registering them keeps the model outputs clean when the code and the power state move together.
    always_comb begin
        mid_thermo         = thermo({1'b0, code[`PDSI_LSB_W +: `PDSI_MID_W]});
        next_primary       = `PDSI_CODE_ZERO;
        next_complementary = `PDSI_CODE_ZERO;
        next_differential  = '0;
        next_upper         = '0;
        next_middle        = '0;
        next_binary        = '0;
        if (!powered_down) begin
            next_primary       = code;
            next_complementary = `PDSI_CODE_MAX - code;
            next_differential  = $signed({1'b0, code, 1'b0}) - $signed({2'b00, `PDSI_CODE_MAX});
            next_upper         = thermo(code[`PDSI_DATA_W-1 -: `PDSI_UPPER_W]);
            next_middle        = mid_thermo[`PDSI_MID_SRC-1:0];
            next_binary        = code[`PDSI_LSB_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            primary_current_output       <= `PDSI_CODE_ZERO;
            complementary_current_output <= `PDSI_CODE_ZERO;
            differential_output          <= '0;
            upper_sources_on             <= '0;
            middle_sources_on            <= '0;
            binary_bits                  <= '0;
        end else begin
            primary_current_output       <= next_primary;
            complementary_current_output <= next_complementary;
            differential_output          <= next_differential;
            upper_sources_on             <= next_upper;
            middle_sources_on            <= next_middle;
            binary_bits                  <= next_binary;
        end
    end
endmodule // pdsi_converter

// ===== dv/pdsi_link_assertions.sv
// Checker for the link pins between the sample source and the converter.
// Assumes the source runs with DIV_HALF of 2: each clock half is two core cycles.
`timescale 1ns/1ps
`include "pdsi_cfg.svh"
module pdsi_link_assertions (
    // Clock and reset
    input wire logic                    core_clk,
    input wire logic                    reset,
    // Link
    input wire logic                    conv_clk_p,
    input wire logic                    conv_clk_n,
    input wire logic                    conv_clk_n_oe,
    input wire logic [`PDSI_DATA_W-1:0] sample_word
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_high;
        conv_clk_p ##1 conv_clk_p ##1 !conv_clk_p;
    endsequence
    sequence s_low;
        !conv_clk_p ##1 !conv_clk_p ##1 conv_clk_p;
    endsequence
    property p_high_half;
        $rose(conv_clk_p) |-> s_high;
    endproperty
    property p_low_half;
        $fell(conv_clk_p) |-> s_low;
    endproperty
    property p_period;
        $rose(conv_clk_p) |-> ##4 $rose(conv_clk_p);
    endproperty
    property p_fall_after;
        $rose(conv_clk_p) |-> ##2 $fell(conv_clk_p);
    endproperty
    // Data must stay away from the sampling edge, so it may only move while the clock is low.
    property p_word_hold;
        conv_clk_p |-> $stable(sample_word);
    endproperty
    property p_word_slot;
        $changed(sample_word) |-> !conv_clk_p && $past(conv_clk_p);
    endproperty
    property p_word_once;
        $changed(sample_word) |=> $stable(sample_word) [*3];
    endproperty
    property p_n_inverse;
        conv_clk_n_oe |-> conv_clk_n == !conv_clk_p;
    endproperty
    a_high_half: assert property (p_high_half) else $error("clock high phase wrong");
    a_low_half: assert property (p_low_half) else $error("clock low phase wrong");
    a_period: assert property (p_period) else $error("clock period wrong");
    a_fall_after: assert property (p_fall_after) else $error("clock duty wrong");
    a_word_hold: assert property (p_word_hold) else $error("word moved while clock high");
    a_word_slot: assert property (p_word_slot) else $error("word moved off the falling edge");
    a_word_once: assert property (p_word_once) else $error("more than one word per period");
    a_n_inverse: assert property (p_n_inverse) else $error("negative clock not inverse");
endmodule // pdsi_link_assertions

// ===== dv/parallel_dac_sample_interface_tb_top.sv
// Self-checking bench joining the sample source and the converter over one link.
// Assumes DIV_HALF of 2 and a short wake count so that the run stays brief.
`timescale 1ns/1ps
`include "pdsi_cfg.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; $display("ERROR %0t mismatch", $time); end end
`define WAIT_FOR(c) begin n = 0; while (!(c) && n < 60) begin @(negedge core_clk); n++; end if (!(c)) begin err_count++; summarize(); end end
module parallel_dac_sample_interface_tb_top;
    logic                 core_clk = 1'h0;
    logic                 reset = 1'h1;
    logic [13:0]          user_word = 14'h0000;
    logic                 user_valid = 1'h0;
    logic                 user_sleep = 1'h0;
    logic                 single_ended = 1'h0;
    logic [1:0]           clock_mode_strap = 2'h1;
    logic                 user_ready;
    logic [13:0]          prim;
    logic [13:0]          comp;
    pdsi_pkg::pdsi_diff_t diff;
    logic [30:0]          upper;
    logic [14:0]          middle;
    logic [4:0]           bin;
    pdsi_pkg::pdsi_clk_mode_e mode;
    logic                 pd;
    int                   err_count = 0;
    int                   check_count = 0;
    pdsi_if pdsi_if_i ();
    pdsi_source #(.DIV_HALF(2)) pdsi_source_i (.core_clk(core_clk), .reset(reset), .user_word(user_word),
        .user_valid(user_valid), .user_ready(user_ready), .user_sleep(user_sleep),
        .single_ended(single_ended), .link(pdsi_if_i.source));
    pdsi_converter #(.SLEEP_CYC(6), .WAKE_CYC(10)) pdsi_converter_i (.core_clk(core_clk), .reset(reset),
        .clock_mode_strap(clock_mode_strap), .link(pdsi_if_i.converter), .primary_current_output(prim),
        .complementary_current_output(comp), .differential_output(diff), .upper_sources_on(upper),
        .middle_sources_on(middle), .binary_bits(bin), .clock_mode(mode), .powered_down(pd));
    pdsi_link_assertions pdsi_link_assertions_i (.core_clk(core_clk), .reset(reset),
        .conv_clk_p(pdsi_if_i.conv_clk_p), .conv_clk_n(pdsi_if_i.conv_clk_n),
        .conv_clk_n_oe(pdsi_if_i.conv_clk_n_oe), .sample_word(pdsi_if_i.sample_word));
    always #4 core_clk = ~core_clk;
    task automatic summarize();
        if (err_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Valid is held until the edge at which ready is seen high, then dropped.
    task automatic send(input logic [13:0] w);
        int n;
        @(posedge core_clk);
        user_word  <= w;
        user_valid <= 1'h1;
        @(negedge core_clk);
        `WAIT_FOR(user_ready === 1'h1)
        @(posedge core_clk);
        user_valid <= 1'h0;
    endtask
    task automatic expect_out(input logic [13:0] c);
        int n;
        `WAIT_FOR(prim === c)
        `CHK(prim, c)
        `CHK(comp, 14'h3fff - c)
        `CHK(diff, pdsi_pkg::pdsi_diff_t'({1'h0, c, 1'h0}) - 16'sh3fff)
        `CHK(upper, 31'((32'h1 << c[13:9]) - 32'h1))
        `CHK(middle, 15'((16'h1 << c[8:5]) - 16'h1))
        `CHK(bin, c[4:0])
    endtask
    task automatic t_codes();
        logic [13:0] codes [4] = '{14'h0000, 14'h2000, 14'h1fff, 14'h2a5b};
        send(14'h3fff);
        expect_out(14'h3fff);
        `CHK(comp, 14'h0000)
        foreach (codes[i]) begin
            send(codes[i]);
            expect_out(codes[i]);
        end
        // Without valid the link repeats the last word, so the outputs must not move.
        @(posedge core_clk);
        user_word <= 14'h0155;
        repeat (12) @(negedge core_clk);
        `CHK(prim, 14'h2a5b)
    endtask
    task automatic t_sleep();
        int n;
        @(posedge core_clk);
        user_sleep <= 1'h1;
        `WAIT_FOR(pd === 1'h1)
        `CHK(n <= 12, 1'h1)
        // The outputs are registered, so they read zero one cycle after the power state turns off.
        @(negedge core_clk);
        `CHK(prim, 14'h0000)
        `CHK(comp, 14'h0000)
        @(posedge core_clk);
        user_sleep <= 1'h0;
        repeat (4) @(negedge core_clk);
        `CHK(pd, 1'h1)
        `WAIT_FOR(pd === 1'h0)
        send(14'h1357);
        expect_out(14'h1357);
    endtask
    task automatic t_strap();
        pdsi_pkg::pdsi_clk_mode_e em [4] = '{pdsi_pkg::PDSI_CLK_SINGLE, pdsi_pkg::PDSI_CLK_DIFF,
                                             pdsi_pkg::PDSI_CLK_PECL, pdsi_pkg::PDSI_CLK_PECL};
        for (int m = 0; m < 4; m++) begin
            @(posedge core_clk);
            clock_mode_strap <= 2'(m);
            single_ended     <= (m == 0);
            reset            <= 1'h1;
            repeat (2) @(posedge core_clk);
            reset <= 1'h0;
            send(14'h0400 + 14'(m));
            expect_out(14'h0400 + 14'(m));
            `CHK(mode, em[m])
            `CHK(pdsi_if_i.conv_clk_n_oe, (m != 0))
        end
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'h0;
        t_codes();
        t_sleep();
        t_strap();
        summarize();
    end
endmodule // parallel_dac_sample_interface_tb_top
